// *** src/lbrg_pkg.sv ***
// package: register map, fields, reset values and types of the baud rate generator
package lbrg_pkg;

  localparam int          LBRG_AW               = 24;
  localparam logic [23:0] LBRG_DIV_HIGH_OFS     = 24'hff_e206;
  localparam logic [23:0] LBRG_DIV_LOW_OFS      = 24'hff_e207;
  localparam logic [23:0] LBRG_CTRL_OFS         = 24'hff_e208;
  localparam logic [23:0] LBRG_STAT_OFS         = 24'hff_e209;

  localparam logic [7:0]  LBRG_DIV_HIGH_RST     = 8'h01;
  localparam logic [7:0]  LBRG_DIV_LOW_RST      = 8'h01;
  localparam logic [7:0]  LBRG_CTRL_RST         = 8'h00;

  // control register fields
  localparam int          LBRG_CTRL_ENABLE_BIT  = 0;
  localparam int          LBRG_CTRL_LIN_BIT     = 1;
  localparam int          LBRG_CTRL_TSEL_BIT    = 2;
  localparam int          LBRG_CTRL_RXEN_BIT    = 3;
  localparam int          LBRG_CTRL_TXON_BIT    = 4;
  // status register fields
  localparam int          LBRG_STAT_TMODE_BIT   = 0;
  localparam int          LBRG_STAT_RUN_BIT     = 1;

  localparam logic [3:0]  LBRG_OVERSAMPLE_LAST  = 4'hf;
  localparam logic [15:0] LBRG_CNT_ONE          = 16'h0001;
  localparam logic [7:0]  LBRG_RD_UNMAPPED      = 8'h00;

  typedef struct packed {
    logic [LBRG_AW-1:0] addr;
    logic [7:0]         wdata;
    logic               wr;
    logic               rd;
  } lbrg_req_t;

  typedef struct packed {
    logic uart_en;
    logic lin_mode;
    logic timer_sel;
    logic rx_en;
    logic transmitter_on;
  } lbrg_ctrl_t;

  typedef enum logic [2:0] {
    LBRG_ST_IDLE  = 3'b001,
    LBRG_ST_BAUD  = 3'b010,
    LBRG_ST_TIMER = 3'b100
  } lbrg_state_t;

endpackage

// *** src/lbrg_down_counter.sv ***
// file: reloading 16-bit down-counter that issues one tick per divisor count
module lbrg_down_counter
  import lbrg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic [15:0] load_value,
  output logic             tick
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_nxt;
  wire         at_end = (cnt_r <= LBRG_CNT_ONE);

  // a zero divisor behaves like one so the counter never stalls
  assign tick_nxt = run & at_end;
  assign cnt_nxt  = !run ? load_value : (at_end ? load_value : cnt_r - LBRG_CNT_ONE);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule

// *** src/lbrg_top.sv ***
// file: baud rate generator of the lin uart with register port and timer mode
//
// Design decision made here: the strobed register port.
module lbrg_top
  import lbrg_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [LBRG_AW-1:0] reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  output logic                    sample_tick,
  output logic                    bit_tick,
  output logic                    rx_timeout_irq,
  output logic                    uart_en,
  output logic                    lin_mode,
  output logic                    transmitter_on
);

  ////////////////////////////////////////////////////////////////////////////
  // register port
  lbrg_req_t   req;
  lbrg_ctrl_t  ctrl_r;
  logic [7:0]  divisor_high_byte_r;
  logic [7:0]  divisor_low_byte_r;
  logic [7:0]  rdata_nxt;
  logic [15:0] rate_divider_value;
  lbrg_state_t state_r;
  lbrg_state_t state_nxt;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic hit(input logic [LBRG_AW-1:0] a, input logic [LBRG_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_high = req.wr & hit(req.addr, LBRG_DIV_HIGH_OFS);
  wire wr_low  = req.wr & hit(req.addr, LBRG_DIV_LOW_OFS);
  wire wr_ctrl = req.wr & hit(req.addr, LBRG_CTRL_OFS);

  // divisor bytes are not shadowed: a half-written value is loaded at the next counter reload,
  // which is why software keeps the uart off while updating them
  assign rate_divider_value = {divisor_high_byte_r, divisor_low_byte_r};

  wire [7:0] ctrl_rd = {3'b000, ctrl_r.transmitter_on, ctrl_r.rx_en, ctrl_r.timer_sel,
                        ctrl_r.lin_mode, ctrl_r.uart_en};
  wire [7:0] stat_rd = {6'b00_0000, state_r != LBRG_ST_IDLE, state_r == LBRG_ST_TIMER};

  assign rdata_nxt = !req.rd ? 8'h00 :
                     hit(req.addr, LBRG_DIV_HIGH_OFS) ? divisor_high_byte_r :
                     hit(req.addr, LBRG_DIV_LOW_OFS)  ? divisor_low_byte_r :
                     hit(req.addr, LBRG_CTRL_OFS)     ? ctrl_rd :
                     hit(req.addr, LBRG_STAT_OFS)     ? stat_rd : LBRG_RD_UNMAPPED;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divisor_high_byte_r <= LBRG_DIV_HIGH_RST;
      divisor_low_byte_r  <= LBRG_DIV_LOW_RST;
      ctrl_r              <= lbrg_ctrl_t'(LBRG_CTRL_RST[4:0]);
      reg_rdata           <= 8'h00;
    end else begin
      if (wr_high) divisor_high_byte_r <= req.wdata;
      if (wr_low)  divisor_low_byte_r  <= req.wdata;
      if (wr_ctrl) begin
        ctrl_r.uart_en        <= req.wdata[LBRG_CTRL_ENABLE_BIT];
        ctrl_r.lin_mode       <= req.wdata[LBRG_CTRL_LIN_BIT];
        ctrl_r.timer_sel      <= req.wdata[LBRG_CTRL_TSEL_BIT];
        ctrl_r.rx_en          <= req.wdata[LBRG_CTRL_RXEN_BIT];
        ctrl_r.transmitter_on <= req.wdata[LBRG_CTRL_TXON_BIT];
      end
      reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode selection
  // timer needs the uart off and the receiver off; the transmitter may stay on
  wire timer_ok = ctrl_r.timer_sel & ~ctrl_r.rx_en & ~ctrl_r.uart_en;

  always_comb begin
    case (state_r)
      LBRG_ST_IDLE:  state_nxt = ctrl_r.uart_en ? LBRG_ST_BAUD :
                                 (timer_ok ? LBRG_ST_TIMER : LBRG_ST_IDLE);
      LBRG_ST_BAUD:  state_nxt = ctrl_r.uart_en ? LBRG_ST_BAUD : LBRG_ST_IDLE;
      LBRG_ST_TIMER: state_nxt = timer_ok ? LBRG_ST_TIMER : LBRG_ST_IDLE;
      default:       state_nxt = LBRG_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) state_r <= LBRG_ST_IDLE;
    else        state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // divisor counter and tick distribution
  logic       div_tick;
  logic [3:0] os_cnt_r;
  logic [3:0] os_cnt_nxt;
  wire        counting = (state_r != LBRG_ST_IDLE) && (state_r == state_nxt);

  lbrg_down_counter u_cnt (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .run        (counting),
    .load_value (rate_divider_value),
    .tick       (div_tick)
  );

  wire in_baud  = (state_r == LBRG_ST_BAUD);
  wire in_timer = (state_r == LBRG_ST_TIMER);
  wire os_wrap  = (os_cnt_r == LBRG_OVERSAMPLE_LAST);

  // standard mode: sixteen divisor ticks per bit; lin mode: one per bit
  assign os_cnt_nxt = !in_baud ? 4'h0 : (div_tick ? os_cnt_r + 4'h1 : os_cnt_r);

  wire bit_nxt = in_baud & div_tick & (ctrl_r.lin_mode | os_wrap);
  wire smp_nxt = in_baud & div_tick & ~ctrl_r.lin_mode;
  wire irq_nxt = in_timer & div_tick;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      os_cnt_r       <= 4'h0;
      sample_tick    <= 1'b0;
      bit_tick       <= 1'b0;
      rx_timeout_irq <= 1'b0;
      uart_en        <= 1'b0;
      lin_mode       <= 1'b0;
      transmitter_on <= 1'b0;
    end else begin
      os_cnt_r       <= os_cnt_nxt;
      sample_tick    <= smp_nxt;
      bit_tick       <= bit_nxt;
      rx_timeout_irq <= irq_nxt;
      uart_en        <= ctrl_r.uart_en;
      lin_mode       <= ctrl_r.lin_mode;
      transmitter_on <= ctrl_r.transmitter_on;
    end
  end

endmodule

// *** bench/lbrg_assertions.sv ***
// checker: port timing of the baud rate generator
module lbrg_assertions
  import lbrg_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic [LBRG_AW-1:0] reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic               sample_tick,
  input wire logic               bit_tick,
  input wire logic               rx_timeout_irq,
  input wire logic               uart_en,
  input wire logic               lin_mode,
  input wire logic               transmitter_on
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] dv_r;
  logic [15:0] gap_r;
  logic        arm_r;
  wire         ev = sample_tick | rx_timeout_irq | (bit_tick & lin_mode);
  wire  [15:0] dv_eff = (dv_r == 16'h0000) ? 16'h0001 : dv_r;
  // any write may change mode or divisor, so the period check rearms
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dv_r  <= {LBRG_DIV_HIGH_RST, LBRG_DIV_LOW_RST};
      gap_r <= 16'h0000;
      arm_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == LBRG_DIV_HIGH_OFS) dv_r[15:8] <= reg_wdata;
      if (reg_wr && reg_addr == LBRG_DIV_LOW_OFS) dv_r[7:0] <= reg_wdata;
      gap_r <= ev ? 16'h0001 : gap_r + 16'h0001;
      arm_r <= reg_wr ? 1'b0 : (ev | arm_r);
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_read_low_byte: assert property (reg_rd && reg_addr == LBRG_DIV_LOW_OFS |=>
    reg_rdata == dv_r[7:0]) else $error("low byte read wrong");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_tick_period: assert property (ev && arm_r |-> gap_r == dv_eff)
    else $error("tick period wrong");
  a_ticks_need_en: assert property ((sample_tick || bit_tick) |->
    uart_en || $past(uart_en)) else $error("tick while disabled");
  a_irq_when_off: assert property (rx_timeout_irq |-> !uart_en || !$past(uart_en))
    else $error("timer irq while enabled");
  a_irq_no_sample: assert property (!(rx_timeout_irq && sample_tick))
    else $error("irq beside sample tick");
  a_bit_on_sample: assert property (bit_tick && !lin_mode && $stable(lin_mode) |->
    sample_tick) else $error("bit tick off sample");
  a_bit_spacing: assert property (bit_tick && !lin_mode |=> !bit_tick [*8])
    else $error("bit ticks too close");
endmodule

bind lbrg_top lbrg_assertions chk (
  .core_clk       (core_clk),
  .rst_n          (rst_n),
  .reg_addr       (reg_addr),
  .reg_wdata      (reg_wdata),
  .reg_wr         (reg_wr),
  .reg_rd         (reg_rd),
  .reg_rdata      (reg_rdata),
  .sample_tick    (sample_tick),
  .bit_tick       (bit_tick),
  .rx_timeout_irq (rx_timeout_irq),
  .uart_en        (uart_en),
  .lin_mode       (lin_mode),
  .transmitter_on (transmitter_on)
);

// *** bench/tb_lbrg_top.sv ***
// testbench: registers and tick timing of the baud rate generator
module tb_lbrg_top
  import lbrg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [15:0] dv;
    logic [7:0]  ct;
    logic [1:0]  sel;
    logic [15:0] e;
  } lbrg_row_t;
  lbrg_row_t rows [6] = '{'{16'h0003, 8'h04, 2'h2, 16'h0003},
    '{16'h0102, 8'h14, 2'h2, 16'h0102}, '{16'h0000, 8'h04, 2'h2, 16'h0001},
    '{16'h0002, 8'h01, 2'h0, 16'h0002}, '{16'h0002, 8'h01, 2'h1, 16'h0020},
    '{16'h0005, 8'h03, 2'h1, 16'h0005}};
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [LBRG_AW-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata;
  logic sample_tick, bit_tick, rx_timeout_irq, uart_en, lin_mode, transmitter_on;
  int fails = 0, check_count = 0, n;
  initial forever #2.5 core_clk = ~core_clk;
  lbrg_top uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sample_tick, .bit_tick, .rx_timeout_irq, .uart_en, .lin_mode, .transmitter_on);
  //////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h saw %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(logic [23:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [23:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  function automatic logic tk(logic [1:0] s);
    return s == 2'h0 ? sample_tick : s == 2'h1 ? bit_tick : rx_timeout_irq;
  endfunction
  // time from one tick to the next, bounded so a dead generator ends the run
  task automatic gap(logic [1:0] s, logic [15:0] e);
    #1 n = 0;
    while (tk(s) !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (tk(s) !== 1'b1 && n < 3000);
    chk("gap", e, n[15:0]);
    if (n >= 3000) close_out();
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(LBRG_CTRL_OFS, 8'h00);
      wr(LBRG_DIV_HIGH_OFS, rows[i].dv[15:8]);
      wr(LBRG_DIV_LOW_OFS, rows[i].dv[7:0]);
      rd(LBRG_DIV_LOW_OFS, rows[i].dv[7:0]);
      rd(LBRG_DIV_HIGH_OFS, rows[i].dv[15:8]);
      wr(LBRG_CTRL_OFS, rows[i].ct);
      gap(rows[i].sel, rows[i].e);
      rd(LBRG_STAT_OFS, rows[i].sel == 2'h2 ? 8'h03 : 8'h02);
      rd(LBRG_CTRL_OFS, rows[i].ct);
      chk("lin", {15'h0000, rows[i].ct[1]}, {15'h0000, lin_mode});
    end
    // receiver on, or uart enabled, keeps the timer quiet
    for (int k = 0; k < 2; k++) begin
      wr(LBRG_CTRL_OFS, k ? 8'h15 : 8'h0c);
      n = 0;
      repeat (40) begin
        @(posedge core_clk);
        #1 if (rx_timeout_irq !== 1'b0) n++;
      end
      chk("noirq", 16'h0000, n[15:0]);
      chk("en", {15'h0000, k[0]}, {15'h0000, uart_en});
      chk("txon", {15'h0000, k[0]}, {15'h0000, transmitter_on});
    end
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(LBRG_DIV_HIGH_OFS, LBRG_DIV_HIGH_RST);
    rd(LBRG_DIV_LOW_OFS, LBRG_DIV_LOW_RST);
    rd(LBRG_CTRL_OFS, LBRG_CTRL_RST);
    rd(24'hff_e20a, LBRG_RD_UNMAPPED);
    rd(LBRG_STAT_OFS, 8'h00);
    chk("en_rst", 16'h0000, {15'h0000, uart_en});
    chk("txon_rst", 16'h0000, {15'h0000, transmitter_on});
    close_out();
  end
endmodule
